// ===== src/indicator_behavior_config_control.sv
// Contract
// R1 - Split bit routes tx and rx separately
// R2 - Pulsing drives lit lamps 5 kHz, 20 percent
// R3 - Rate field picks blink and stretch timing
// R4 - Only first port's rate field is used
// R5 - Per-lamp select: stretch or blink
// R6 - Per-lamp combine disable shows base only
// R7 - Configuration survives all but power reset
// R8 - Copper-only bit drops fiber from link lamp
// R9 - Stretch holds after event; blink toggles while active
`timescale 1ns/1ns
`default_nettype none
`include "indicator_behavior_config_regs.svh"
module indicator_behavior_config_control
    import indicator_behavior_config_pkg::*;
#(
    parameter int TICK_CYC = `IND_TICK_MS * `IND_CLK_KHZ, // 25 ms base tick
    parameter int PWM_CYC = (`IND_CLK_KHZ * 1000) / `IND_PWM_HZ, // Pulse period
    parameter int PWM_HI_CYC = PWM_CYC * `IND_PWM_DUTY_PCT / 100 // Pulse high time
) (
    input wire logic CLK, // System clock
    input wire logic RST, // Async reset, high
    input wire logic CE, // Clock enable
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic [3:0] PSTRB, // APB byte strobes
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic [7:0] STRAP_CFG, // Strap defaults, bits 7:4 and 3:0 for cfg bits 8:5 and 3:0
    input wire port_stat_s [`IND_NUM_PORTS-1:0] PORT_STATUS, // Status pins
    output ind_t INDICATOR_OUT_0, // Lamp 0 per port
    output ind_t INDICATOR_OUT_1, // Lamp 1 per port
    output ind_t INDICATOR_OUT_2, // Lamp 2 per port
    output ind_t INDICATOR_OUT_3 // Lamp 3 per port
);
    localparam int NP = `IND_NUM_PORTS;
    localparam int NL = `IND_NUM_LEDS;

    // ==================================================
    // State
    typedef struct packed {
        port_stat_s [NP-1:0] sync1; // First sync stage
        port_stat_s [NP-1:0] sync2; // Second sync stage
        logic [7:0] strap1; // Strap sync stage 1
        logic [7:0] strap2; // Strap sync stage 2
        logic [1:0] strap_cnt; // Wait for synced strap
        logic strap_done; // Strap defaults loaded
        logic [NP-1:0][15:0] cfg; // Behaviour registers
        logic [`IND_TICK_W-1:0] tick_cnt; // Base tick prescaler
        logic [2:0] tick_div; // Tick divider for blink
        logic phase; // Blink phase
        logic [`IND_PWM_W-1:0] pwm_cnt; // Pulse counter
        logic [NP-1:0][NL-1:0][`IND_STR_W-1:0] stretch; // Stretch timers
        logic [NL-1:0][NP-1:0] outs; // Lamp drive
        logic pready; // Ready flop
        logic pslverr; // Error flop
        logic [31:0] prdata; // Read data flop
    } state_s;

    state_s s_r; // Registered state
    state_s s_nxt; // Next state
    logic [NP-1:0][NL-1:0] base_w; // Steady condition per lamp
    logic [NP-1:0][NL-1:0] evt_w; // Event condition per lamp
    logic [NP-1:0][NL-1:0] disp_w; // Shaped event per lamp
    logic [NP-1:0][NL-1:0] on_w; // Lamp lit before pulsing
    logic [1:0] rate_w; // Global rate
    logic [2:0] mask_w; // Blink divider mask
    logic [`IND_STR_W-1:0] load_w; // Stretch reload
    logic tick_w; // Base tick this cycle
    logic pwm_hi_w; // Pulse high window
    logic access_w; // First access cycle
    logic hit_w; // Address decodes
    logic wr_w; // Write takes effect
    logic [`IND_PORT_BITS-1:0] port_w; // Addressed port
    logic [15:0] wmask_w; // Byte-lane write mask
    port_stat_s st; // Port status scratch

    // ==================================================
    // Next-state logic
    always_comb
    begin
        s_nxt = s_r;
        st = '0;
        // Synchronise pins; stage one feeds stage two only
        s_nxt.sync1 = PORT_STATUS;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.strap1 = STRAP_CFG;
        s_nxt.strap2 = s_r.strap1;
        // One wait state; decode on the first access cycle
        access_w = PSEL && PENABLE && !s_r.pready;
        port_w = PADDR[8:7];
        hit_w = (PADDR[11:9] == 3'h0) && (PADDR[6:2] == `IND_CFG_INDEX) && (PADDR[1:0] == 2'h0);
        wr_w = access_w && PWRITE && hit_w;
        wmask_w = {{8{PSTRB[1]}}, {8{PSTRB[0]}}} & `IND_WR_MASK;
        s_nxt.pready = access_w;
        s_nxt.pslverr = access_w && !hit_w;
        s_nxt.prdata = '0;
        if (access_w && !PWRITE && hit_w)
        begin
            // Reserved bits read zero
            s_nxt.prdata = {16'h0000, s_r.cfg[port_w] & `IND_WR_MASK};
        end
        // Strap defaults load once after release; after that only bus writes touch cfg
        if (!s_r.strap_done)
        begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            if (s_r.strap_cnt == 2'h2)
            begin
                s_nxt.strap_done = 1'b1;
                for (int p = 0; p < NP; p++)
                begin
                    s_nxt.cfg[p][8:5] = s_r.strap2[7:4]; // see R7
                    s_nxt.cfg[p][3:0] = s_r.strap2[3:0]; // see R7
                end
            end
        end
        else if (wr_w)
        begin
            // Only bus writes change a configured value
            s_nxt.cfg[port_w] = (s_r.cfg[port_w] & ~wmask_w) | (PWDATA[15:0] & wmask_w); // see R7
        end
        // Global timing from the first port only
        rate_w = s_r.cfg[0][`IND_RATE_HI:`IND_RATE_LO]; // see R4
        mask_w = 3'(3'h7 >> rate_w); // see R3
        load_w = `IND_STR_W'((5'h02 << (2'h3 - rate_w)) + 5'h01); // see R3
        tick_w = (s_r.tick_cnt == `IND_TICK_W'(TICK_CYC - 1));
        s_nxt.tick_cnt = tick_w ? '0 : s_r.tick_cnt + 1'b1;
        if (tick_w)
        begin
            s_nxt.tick_div = s_r.tick_div + 3'h1;
            // Toggle every 2^(3-rate) ticks of 25 ms
            if ((s_r.tick_div & mask_w) == mask_w)
            begin
                s_nxt.phase = !s_r.phase; // see R3
            end
        end
        s_nxt.pwm_cnt = (s_r.pwm_cnt == `IND_PWM_W'(PWM_CYC - 1)) ? '0 : s_r.pwm_cnt + 1'b1;
        pwm_hi_w = (s_r.pwm_cnt < `IND_PWM_W'(PWM_HI_CYC)); // see R2
        // Per-port lamp conditions
        for (int p = 0; p < NP; p++)
        begin
            st = s_r.sync2[p];
            base_w[p][0] = s_r.cfg[p][`IND_COPPER_ONLY] ? st.copper_link
                : (st.copper_link || st.fiber_link); // see R8
            base_w[p][1] = st.fiber_link;
            base_w[p][2] = st.duplex;
            base_w[p][3] = st.copper_link;
            evt_w[p][0] = s_r.cfg[p][`IND_ACT_SPLIT] ? st.tx_act
                : (st.tx_act || st.rx_act); // see R1
            evt_w[p][1] = s_r.cfg[p][`IND_ACT_SPLIT] ? st.rx_act : st.fiber_act; // see R1
            evt_w[p][2] = st.collision;
            evt_w[p][3] = s_r.cfg[p][`IND_ACT_SPLIT] ? st.tx_act
                : (st.tx_act || st.rx_act); // see R1
            for (int j = 0; j < NL; j++)
            begin
                // Stretch timer restarts on every event, counts ticks
                if (evt_w[p][j])
                begin
                    s_nxt.stretch[p][j] = load_w; // see R9
                end
                else if (tick_w && (s_r.stretch[p][j] != '0))
                begin
                    s_nxt.stretch[p][j] = s_r.stretch[p][j] - 1'b1;
                end
                if (s_r.cfg[p][`IND_STRETCH_SEL0 + j])
                begin
                    disp_w[p][j] = evt_w[p][j] || (s_r.stretch[p][j] != '0); // see R5
                end
                else
                begin
                    disp_w[p][j] = evt_w[p][j] && s_r.phase; // see R5
                end
                // Combined lamps flip away from the base level on activity
                on_w[p][j] = s_r.cfg[p][`IND_COMBINE_DIS0 + j] ? base_w[p][j]
                    : (base_w[p][j] ^ disp_w[p][j]); // see R6
                s_nxt.outs[j][p] = on_w[p][j] &&
                    (!s_r.cfg[p][`IND_PULSE_EN] || pwm_hi_w); // see R2
            end
        end
    end

    // ==================================================
    // State register; cfg is cleared only by RST
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            s_r <= '0;
        end
        else if (CE)
        begin
            s_r <= s_nxt;
        end
    end

    // ==================================================
    // Outputs straight from flops
    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign INDICATOR_OUT_0 = s_r.outs[0];
    assign INDICATOR_OUT_1 = s_r.outs[1];
    assign INDICATOR_OUT_2 = s_r.outs[2];
    assign INDICATOR_OUT_3 = s_r.outs[3];

    // ==================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST || !CE);

    a_bus_wait: assert property (access_w |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after access");
    // Split sends transmit to both activity lamps and receive to lamp 1
    a_split_route: assert property (s_r.cfg[0][`IND_ACT_SPLIT] |-> // see R1
        (evt_w[0][0] == s_r.sync2[0].tx_act && evt_w[0][3] == s_r.sync2[0].tx_act
        && evt_w[0][1] == s_r.sync2[0].rx_act))
        else $error("split routing wrong");
    a_pulse_gate: assert property (s_r.cfg[0][`IND_PULSE_EN] && !pwm_hi_w // see R2
        |=> !INDICATOR_OUT_0[0])
        else $error("pulse low window lit");
    // Expected decode written as a table, not the shift used above
    a_rate_mask: assert property (( // see R3
        (s_r.cfg[0][11:10] != 2'h0 || (mask_w == 3'h7 && load_w == 5'h11))
        && (s_r.cfg[0][11:10] != 2'h1 || (mask_w == 3'h3 && load_w == 5'h09))
        && (s_r.cfg[0][11:10] != 2'h2 || (mask_w == 3'h1 && load_w == 5'h05))
        && (s_r.cfg[0][11:10] != 2'h3 || (mask_w == 3'h0 && load_w == 5'h03))))
        else $error("rate decode wrong");
    a_rate_global: assert property ($stable(s_r.cfg[0][11:10]) |-> $stable(mask_w)) // see R4
        else $error("rate follows other port");
    a_blink_idle: assert property (!s_r.cfg[1][`IND_STRETCH_SEL0] && !evt_w[1][0] // see R5
        |-> !disp_w[1][0])
        else $error("blink without event");
    a_combine_off: assert property (s_r.cfg[0][`IND_COMBINE_DIS0] |-> // see R6
        on_w[0][0] == base_w[0][0])
        else $error("combine not disabled");
    a_cfg_sticky: assert property (s_r.strap_done && !wr_w |=> $stable(s_r.cfg)) // see R7
        else $error("cfg changed without write");
    a_copper_only: assert property (s_r.cfg[0][`IND_COPPER_ONLY] |-> // see R8
        base_w[0][0] == s_r.sync2[0].copper_link)
        else $error("fiber leaks to link lamp");
    a_stretch_hold: assert property (evt_w[0][0] |=> s_r.stretch[0][0] >= 5'h03) // see R9
        else $error("stretch not loaded");
endmodule
`default_nettype wire

// ===== src/indicator_behavior_config_pkg.sv
`include "indicator_behavior_config_regs.svh"
package indicator_behavior_config_pkg;
    // ==================================================
    // Per-port status carried in from the PHY core
    typedef struct packed {
        logic copper_link; // Copper link up
        logic fiber_link; // Fiber link up
        logic tx_act; // Transmit activity
        logic rx_act; // Receive activity
        logic fiber_act; // Fiber activity
        logic duplex; // Full duplex
        logic collision; // Collision seen
    } port_stat_s;
    typedef logic [`IND_NUM_PORTS-1:0] ind_t;
endpackage

// ===== src/indicator_behavior_config_regs.svh
`ifndef INDICATOR_BEHAVIOR_CONFIG_REGS_SVH
`define INDICATOR_BEHAVIOR_CONFIG_REGS_SVH
// ==================================================
// Geometry
`define IND_NUM_PORTS 4
`define IND_NUM_LEDS 4
// ==================================================
// Register placement (word index, byte address is four times it)
`define IND_CFG_INDEX 5'h1e
`define IND_PORT_BITS 2
// ==================================================
// Field positions
`define IND_COPPER_ONLY 15
`define IND_ACT_SPLIT 14
`define IND_PULSE_EN 12
`define IND_RATE_HI 11
`define IND_RATE_LO 10
`define IND_STRETCH_SEL0 5
`define IND_COMBINE_DIS0 0
`define IND_WR_MASK 16'hddef
`define IND_CFG_RESET 16'h0000
// ==================================================
// Timing
`define IND_CLK_KHZ 50000
`define IND_TICK_MS 25
`define IND_PWM_HZ 5000
`define IND_PWM_DUTY_PCT 20
`define IND_TICK_W 21
`define IND_PWM_W 14
`define IND_STR_W 5
`endif

// ===== tb/lamp_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// Lamp bank seen by a light sensor on port 0
module lamp_model
    import indicator_behavior_config_pkg::*;
(
    input wire logic clk, // Sample clock
    input wire logic clr, // Restart the count
    input wire ind_t lamp, // Lamp drive per port
    output int lit_cnt // Lit cycles so far
);
    // Integrates light, since a 5 kHz flicker is only visible as brightness
    always @(posedge clk)
        lit_cnt <= clr ? 0 : lit_cnt + int'(lamp[0]);
endmodule
`default_nettype wire

// ===== tb/test_indicator_behavior_config_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_indicator_behavior_config_control
    import indicator_behavior_config_pkg::*;
;
    // ==================================================
    // Bench signals
    logic CLK = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, clr = 1;
    logic PREADY, PSLVERR, err;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic [7:0] STRAP_CFG = 8'ha5; // Strap defaults for stretch and combine
    port_stat_s [3:0] st = '0; // Status pins per port
    ind_t l0, l1, l2, l3;
    int n_fail = 0, checks_done = 0, lit;
    // Short tick and pulse period keep the run brief
    indicator_behavior_config_control #(.TICK_CYC(20), .PWM_CYC(10), .PWM_HI_CYC(2)) dut (.CLK(CLK),
        .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'h3), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .STRAP_CFG(STRAP_CFG), .PORT_STATUS(st),
        .INDICATOR_OUT_0(l0), .INDICATOR_OUT_1(l1), .INDICATOR_OUT_2(l2),
        .INDICATOR_OUT_3(l3));
    lamp_model lamps (.clk(CLK), .clr(clr), .lamp(l0), .lit_cnt(lit));
    always #10 CLK = ~CLK;
    // ==================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the idle cycle after it avoids re-driving PSEL in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 20 && PREADY !== 1'b1; i++)
            @(posedge CLK);
        if (i == 20)
        begin
            check("apb wait", 1, 0);
            report_and_stop();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_regs();
        apb(0, 12'h078, 0);
        check("strap port0", 32'h0000_0145, rd);
        check("read ok", 0, {31'h0, err});
        apb(1, 12'h0f8, 32'hffff_ffff);
        apb(0, 12'h0f8, 0);
        check("mask port1", 32'h0000_ddef, rd);
        apb(0, 12'h07c, 0);
        check("unmapped err", 1, {31'h0, err});
        check("unmapped data", 0, rd);
        apb(1, 12'h278, 32'h0000_ffff);
        check("bit9 err", 1, {31'h0, err});
        $display("t_regs done");
    endtask
    task automatic t_combine();
        st <= 28'h000_0050; // Port 0 copper link and transmit
        apb(1, 12'h078, 32'h0000_01e1);
        repeat (5) @(posedge CLK);
        check("lamp0 base only", 1, {31'h0, l0[0]});
        apb(1, 12'h078, 32'h0000_01e0);
        repeat (5) @(posedge CLK);
        check("lamp0 link xor act", 0, {31'h0, l0[0]});
        st <= 28'h000_0020; // Port 0 fiber link only
        apb(1, 12'h078, 32'h0000_01e1);
        repeat (5) @(posedge CLK);
        check("fiber merged", 1, {31'h0, l0[0]});
        apb(1, 12'h078, 32'h0000_81e1);
        repeat (5) @(posedge CLK);
        check("copper only", 0, {31'h0, l0[0]});
        $display("t_combine done");
    endtask
    task automatic t_split();
        st <= '0;
        apb(1, 12'h078, 32'h0000_4de0);
        repeat (400) @(posedge CLK);
        st[0].rx_act <= 1'b1;
        repeat (5) @(posedge CLK);
        check("rx on lamp1", 1, {31'h0, l1[0]});
        check("no tx on lamp3", 0, {31'h0, l3[0]});
        apb(1, 12'h078, 32'h0000_0de0);
        repeat (5) @(posedge CLK);
        check("rx on lamp3", 1, {31'h0, l3[0]});
        $display("t_split done");
    endtask
    task automatic t_rate();
        st <= '0;
        apb(1, 12'h0f8, 32'h0000_01e0);
        repeat (400) @(posedge CLK);
        st[1].tx_act <= 1'b1;
        @(posedge CLK);
        st[1].tx_act <= 1'b0;
        repeat (40) @(posedge CLK);
        check("stretch held", 1, {31'h0, l0[1]});
        repeat (80) @(posedge CLK);
        check("port0 rate used", 0, {31'h0, l0[1]});
        $display("t_rate done");
    endtask
    task automatic t_pulse();
        st[0].copper_link <= 1'b1;
        apb(1, 12'h078, 32'h0000_11e1);
        repeat (5) @(posedge CLK);
        clr <= 1'b0;
        repeat (101) @(posedge CLK);
        check("pulsed lit", 20, lit);
        clr <= 1'b1;
        apb(1, 12'h078, 32'h0000_01e1);
        clr <= 1'b0;
        repeat (101) @(posedge CLK);
        check("steady lit", 100, lit);
        $display("t_pulse done");
    endtask
    // Blink at the slowest rate lights the lamp half of one full period
    task automatic t_blink();
        clr <= 1'b1;
        st <= 28'h000_0010; // Port 0 transmits, no link
        apb(1, 12'h078, 32'h0000_0000);
        repeat (5) @(posedge CLK);
        clr <= 1'b0;
        repeat (321) @(posedge CLK);
        check("blink half lit", 160, lit);
        $display("t_blink done");
    endtask
    // Duplex lamp, then clock enable low must freeze it
    task automatic t_freeze();
        st <= 28'h000_0002; // Port 0 full duplex only
        repeat (5) @(posedge CLK);
        check("duplex lamp", 1, {31'h0, l2[0]});
        st <= '0;
        CE <= 1'b0;
        repeat (10) @(posedge CLK);
        check("frozen lamp", 1, {31'h0, l2[0]});
        CE <= 1'b1;
        repeat (5) @(posedge CLK);
        check("thawed lamp", 0, {31'h0, l2[0]});
        $display("t_freeze done");
    endtask
    initial
    begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        repeat (6) @(posedge CLK);
        t_regs();
        t_combine();
        t_split();
        t_rate();
        t_pulse();
        t_blink();
        t_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
